// file: core/wkr_ctrl.sv
// Control of a three-channel wake-up receiver: registers, channel power states, pin routing.
// Assumes register writes arrive already deframed on clk_sys; detector levels and chip select are asynchronous.
`timescale 1ns/1ps

module wkr_ctrl
  import wkr_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = `WKR_RX_TIMEOUT_CYC
)(
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       wr_stb,
  input  wire logic [1:0] wr_addr,
  input  wire logic [5:0] wr_data,
  input  wire logic       cs_pin,
  input  wire logic [2:0] sig_det,
  input  wire logic [2:0] rx_data,
  input  wire logic [2:0] matcher_hit,
  output wkr_ana_t        ana_ctl,
  output logic            wake_n,
  output logic            rssi_dout,
  output logic            rssi_oe_n,
  output logic [2:0]      ch_receive
);

  localparam logic [`WKR_TMO_W-1:0] TMO_LIM = TIMEOUT_CYC[`WKR_TMO_W-1:0];

  // Counter width must hold the timeout
  if (TIMEOUT_CYC < 1 || TIMEOUT_CYC >= (1 << `WKR_TMO_W))
  begin : g_bad_timeout
    $error("TIMEOUT_CYC out of range");
  end

  wkr_state_t st_r;
  wkr_state_t st_nxt;
  logic [2:0] chan_en;
  logic [2:0] hit_ok;
  logic [1:0] probe;
  logic [1:0] diag_sel;
  logic       any_wake;
  logic       sel_wake;
  logic       sel_data;

  // One of three by probe code; code 11 yields zero
  function automatic logic sel3(input logic [2:0] v, input logic [1:0] s);
    logic r;
    r = 1'b0;
    case (s)
      2'h0: r = v[0];
      2'h1: r = v[1];
      2'h2: r = v[2];
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Invalid zero-half-bits allowed: 3 minus the code {hi, lo}
  function automatic logic [1:0] zero_tol(input wkr_mcfg_t m);
    return 2'h3 - {m.zero_tolerance_hi, m.zero_tolerance_lo};
  endfunction

  // Decoded views of the current registers
  assign chan_en  = {st_r.power.channel_three_on, st_r.power.channel_two_on, st_r.power.channel_one_on};
  assign probe    = {st_r.chsel.probe_channel_hi, st_r.chsel.probe_channel_lo};
  assign diag_sel = {st_r.test.diag_select_hi, st_r.test.diag_select_lo};
  assign any_wake = (|st_r.wake_lat) | st_r.por_wake;
  assign sel_wake = sel3(st_r.wake_lat, probe);
  assign sel_data = sel3(st_r.dat_s2, probe);

  // Matcher hits only count in receive with the matcher clocked
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      hit_ok[i] = matcher_hit[i] && st_r.ch_st[i] == WKR_CH_RECEIVE
                  && !st_r.mcfg.matcher_clock_off;
    end
  end

  // Next state
  always_comb
  begin
    st_nxt = st_r;

    // Two-flop synchronisers for pins and detector levels
    st_nxt.cs_s1  = cs_pin;
    st_nxt.cs_s2  = st_r.cs_s1;
    st_nxt.det_s1 = sig_det;
    st_nxt.det_s2 = st_r.det_s1;
    st_nxt.dat_s1 = rx_data;
    st_nxt.dat_s2 = st_r.dat_s1;

    // Writes are never gated by power state, so sleep can be left
    if (wr_stb)
    begin
      case (wr_addr)
        `WKR_ADDR_POWER: st_nxt.power = wr_data;
        `WKR_ADDR_CHSEL: st_nxt.chsel = wr_data;
        `WKR_ADDR_TEST:  st_nxt.test  = wr_data;
        `WKR_ADDR_MCFG:  st_nxt.mcfg  = wr_data;
        default: st_nxt.mcfg = st_r.mcfg;
      endcase
    end

    // Per-channel power states
    for (int i = 0; i < 3; i++)
    begin
      case (st_r.ch_st[i])
        WKR_CH_OFF:
        begin
          if (chan_en[i])
            st_nxt.ch_st[i] = WKR_CH_STANDBY;
        end
        WKR_CH_STANDBY:
        begin
          st_nxt.tmo_cnt[i] = '0;
          if (!chan_en[i])
            st_nxt.ch_st[i] = WKR_CH_OFF;
          else if (st_r.det_s2[i])
            st_nxt.ch_st[i] = WKR_CH_RECEIVE;
        end
        WKR_CH_RECEIVE:
        begin
          if (!chan_en[i])
            st_nxt.ch_st[i] = WKR_CH_OFF;
          else if (st_r.det_s2[i])
            st_nxt.tmo_cnt[i] = '0;
          else if (st_r.tmo_cnt[i] >= TMO_LIM)
            st_nxt.ch_st[i] = WKR_CH_STANDBY;
          else
            st_nxt.tmo_cnt[i] = st_r.tmo_cnt[i] + 1'b1;
        end
        default: st_nxt.ch_st[i] = WKR_CH_OFF;
      endcase

      // Pattern counting; a half pair is dropped when receive ends
      if (hit_ok[i])
      begin
        if (!st_r.mcfg.pattern_repeat_select || st_r.hit_pend[i])
        begin
          st_nxt.wake_lat[i] = 1'b1;
          st_nxt.hit_pend[i] = 1'b0;
        end
        else
          st_nxt.hit_pend[i] = 1'b1;
      end
      if (st_nxt.ch_st[i] != WKR_CH_RECEIVE)
        st_nxt.hit_pend[i] = 1'b0;
    end

    // Release holds every detection clear, power-on wake included
    if (st_r.chsel.wake_release)
    begin
      st_nxt.wake_lat = '0;
      st_nxt.hit_pend = '0;
      st_nxt.por_wake = 1'b0;
    end

    // Front-end controls, one cycle behind the registers
    for (int i = 0; i < 3; i++)
    begin
      st_nxt.ana.amp_on[i]         = st_r.ch_st[i] != WKR_CH_OFF;
      st_nxt.ana.matcher_pwr[i]    = st_r.ch_st[i] == WKR_CH_RECEIVE;
      st_nxt.ana.matcher_clk_en[i] = st_r.ch_st[i] == WKR_CH_RECEIVE
                                     && !st_r.mcfg.matcher_clock_off;
      st_nxt.ch_receive[i]         = st_r.ch_st[i] == WKR_CH_RECEIVE;
    end
    st_nxt.ana.repeat_double  = st_r.mcfg.pattern_repeat_select;
    st_nxt.ana.zero_tol       = zero_tol(st_r.mcfg);
    st_nxt.ana.tau_large      = st_r.mcfg.threshold_filter_tau;
    st_nxt.ana.input_short    = st_r.power.antenna_route_hi && st_r.power.antenna_route_lo;
    st_nxt.ana.antenna_mode   = {st_r.power.antenna_route_hi, st_r.power.antenna_route_lo};
    st_nxt.ana.damping_on     = st_r.chsel.input_damping_on;
    st_nxt.ana.regulator_on   = st_r.power.regulator_on;
    st_nxt.ana.rssi_step_high = st_r.test.rssi_step_high;

    // Wake pin, active low; diagnostic mux overrides the normal path
    if (st_r.test.diag_mux_on)
    begin
      case (diag_sel)
        `WKR_DIAG_DATA: st_nxt.wake_n = sel_data;
        `WKR_DIAG_WAKE: st_nxt.wake_n = !sel_wake;
        default: st_nxt.wake_n = 1'b1; // Unused codes park the pin inactive
      endcase
    end
    else if (st_r.chsel.wake_release)
      st_nxt.wake_n = 1'b1;
    else
      st_nxt.wake_n = !any_wake;

    // Aux pin, independent of the wake pin path
    st_nxt.rssi_oe_n = !(st_r.cs_s2
                         && {st_r.chsel.aux_pin_mode_hi, st_r.chsel.aux_pin_mode_lo} == `WKR_AUX_DIGITAL);
    if (probe == `WKR_PROBE_ALL)
      st_nxt.rssi_dout = !any_wake;
    else if (diag_sel == `WKR_DIAG_WAKE)
      st_nxt.rssi_dout = !sel_wake;
    else if (diag_sel == `WKR_DIAG_DATA)
      st_nxt.rssi_dout = sel_data;
    else
      st_nxt.rssi_dout = 1'b1;
  end

  // State register; power-on activates the wake pin until released
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r           <= '0;
      st_r.power     <= `WKR_RST_POWER;
      st_r.chsel     <= `WKR_RST_CHSEL;
      st_r.test      <= `WKR_RST_TEST;
      st_r.mcfg      <= `WKR_RST_MCFG;
      st_r.por_wake  <= 1'b1;
      st_r.rssi_oe_n <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  // Outputs come straight from the state register
  assign ana_ctl    = st_r.ana;
  assign wake_n     = st_r.wake_n;
  assign rssi_dout  = st_r.rssi_dout;
  assign rssi_oe_n  = st_r.rssi_oe_n;
  assign ch_receive = st_r.ch_receive;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_ch0_rx_hit;
    hit_ok[0] && !st_r.chsel.wake_release;
  endsequence

  sequence s_ch0_quiet_end;
    st_r.ch_st[0] == WKR_CH_RECEIVE && chan_en[0] && !st_r.det_s2[0] && st_r.tmo_cnt[0] >= TMO_LIM;
  endsequence

  property p_clk_off;
    st_r.mcfg.matcher_clock_off |=> ana_ctl.matcher_clk_en == 3'h0;
  endproperty
  a_clk_off: assert property (p_clk_off) else $error("matcher clock running while off");

  property p_single_wake;
    s_ch0_rx_hit ##0 !st_r.mcfg.pattern_repeat_select |=> st_r.wake_lat[0];
  endproperty
  a_single_wake: assert property (p_single_wake) else $error("single pattern did not wake");

  property p_double_first;
    s_ch0_rx_hit ##0 (st_r.mcfg.pattern_repeat_select && !st_r.hit_pend[0] && !st_r.wake_lat[0])
      |=> !st_r.wake_lat[0];
  endproperty
  a_double_first: assert property (p_double_first) else $error("first of two patterns woke");

  property p_zero_tol;
    st_r.mcfg.zero_tolerance_lo && !st_r.mcfg.zero_tolerance_hi |=> ana_ctl.zero_tol == 2'h2;
  endproperty
  a_zero_tol: assert property (p_zero_tol) else $error("zero tolerance code wrong");

  property p_sleep;
    chan_en == 3'h0 ##1 chan_en == 3'h0 |=> ana_ctl.amp_on == 3'h0 && ch_receive == 3'h0;
  endproperty
  a_sleep: assert property (p_sleep) else $error("channel on in sleep");

  property p_standby_rx;
    st_r.ch_st[0] == WKR_CH_STANDBY && chan_en[0] && st_r.det_s2[0]
      |=> st_r.ch_st[0] == WKR_CH_RECEIVE ##1 ch_receive[0] && ana_ctl.matcher_pwr[0];
  endproperty
  a_standby_rx: assert property (p_standby_rx) else $error("standby did not enter receive");

  property p_timeout;
    s_ch0_quiet_end |=> st_r.ch_st[0] == WKR_CH_STANDBY ##1 !ana_ctl.matcher_pwr[0] && ana_ctl.amp_on[0];
  endproperty
  a_timeout: assert property (p_timeout) else $error("receive timeout not taken");

  property p_tmo_bound;
    st_r.tmo_cnt[0] <= TMO_LIM;
  endproperty
  a_tmo_bound: assert property (p_tmo_bound) else $error("timeout counter overran");

  property p_cs_float;
    !st_r.cs_s2 |=> rssi_oe_n;
  endproperty
  a_cs_float: assert property (p_cs_float) else $error("aux pin driven without chip select");

  property p_or_wake;
    !st_r.test.diag_mux_on && !st_r.chsel.wake_release |=> wake_n == !$past(any_wake);
  endproperty
  a_or_wake: assert property (p_or_wake) else $error("wake pin not the OR of channels");

  property p_release;
    (st_r.chsel.wake_release && !st_r.test.diag_mux_on) [*2] |-> wake_n ##1 st_r.wake_lat == 3'h0;
  endproperty
  a_release: assert property (p_release) else $error("release did not hold wake high");

  property p_diag_wake;
    st_r.test.diag_mux_on && diag_sel == `WKR_DIAG_WAKE && probe == 2'h1
      |=> wake_n == !$past(st_r.wake_lat[1]);
  endproperty
  a_diag_wake: assert property (p_diag_wake) else $error("diagnostic wake shows wrong channel");

  // A hit that arrives while the matcher clocks are stopped must not latch
  property p_no_wake_clk_off;
    matcher_hit[0] && st_r.mcfg.matcher_clock_off && !st_r.wake_lat[0] |=> !st_r.wake_lat[0];
  endproperty
  a_no_wake_clk_off: assert property (p_no_wake_clk_off) else $error("wake raised with clock off");

  property p_short;
    st_r.power.antenna_route_hi && st_r.power.antenna_route_lo |=> ana_ctl.input_short;
  endproperty
  a_short: assert property (p_short) else $error("inputs not shorted");

  property p_damping;
    st_r.chsel.input_damping_on |=> ana_ctl.damping_on;
  endproperty
  a_damping: assert property (p_damping) else $error("attenuator not connected");

  property p_aux_comb;
    probe == `WKR_PROBE_ALL |=> rssi_dout == !$past(any_wake);
  endproperty
  a_aux_comb: assert property (p_aux_comb) else $error("aux pin not the combined wake");

endmodule

// file: core/wkr_defines.svh
// Register addresses, reset values and timing counts of the wake-up receiver control.
// Assumes a 40 MHz system clock; included by the package and by the bench modules.
`ifndef WKR_DEFINES_SVH
`define WKR_DEFINES_SVH

// Register address {A1, A0}
`define WKR_ADDR_POWER 2'h0
`define WKR_ADDR_CHSEL 2'h1
`define WKR_ADDR_TEST  2'h2
`define WKR_ADDR_MCFG  2'h3

// Power-on values of the four six-bit registers
`define WKR_RST_POWER 6'h0f
`define WKR_RST_CHSEL 6'h00
`define WKR_RST_TEST  6'h10
`define WKR_RST_MCFG  6'h18

// Probe channel, diagnostic select and aux pin mode codes {hi, lo}
`define WKR_PROBE_ALL   2'h3
`define WKR_DIAG_DATA   2'h0
`define WKR_DIAG_WAKE   2'h1
`define WKR_AUX_DIGITAL 2'h2

// Receive timeout, in microseconds and in system clocks
`define WKR_CLK_KHZ        40000
`define WKR_RX_TIMEOUT_US  3300
`define WKR_RX_TIMEOUT_CYC ((`WKR_RX_TIMEOUT_US * `WKR_CLK_KHZ) / 1000)
`define WKR_TMO_W          18

`endif

// file: core/wkr_pkg.sv
// Types of the wake-up receiver control: register layouts, channel states, state record.
// Assumes wkr_defines.svh is on the include path.
package wkr_pkg;
  `include "wkr_defines.svh"

  // Power register, bit 0 first from the bottom
  typedef struct packed {
    logic antenna_route_hi;
    logic antenna_route_lo;
    logic regulator_on;
    logic channel_three_on;
    logic channel_two_on;
    logic channel_one_on;
  } wkr_power_t;

  // Channel select register
  typedef struct packed {
    logic wake_release;
    logic input_damping_on;
    logic aux_pin_mode_hi;
    logic aux_pin_mode_lo;
    logic probe_channel_hi;
    logic probe_channel_lo;
  } wkr_chsel_t;

  // Diagnostic register
  typedef struct packed {
    logic wake_gen_on;
    logic rssi_step_high;
    logic test_spare;
    logic diag_select_hi;
    logic diag_select_lo;
    logic diag_mux_on;
  } wkr_test_t;

  // Pattern matcher configuration register
  typedef struct packed {
    logic spare_must_zero;
    logic threshold_filter_tau;
    logic zero_tolerance_hi;
    logic zero_tolerance_lo;
    logic pattern_repeat_select;
    logic matcher_clock_off;
  } wkr_mcfg_t;

  typedef enum logic [1:0] {
    WKR_CH_OFF     = 2'b00,
    WKR_CH_STANDBY = 2'b01,
    WKR_CH_RECEIVE = 2'b10
  } wkr_ch_state_t;

  // Controls toward the analog front end and the matchers
  typedef struct packed {
    logic [2:0] amp_on;
    logic [2:0] matcher_pwr;
    logic [2:0] matcher_clk_en;
    logic       repeat_double;
    logic [1:0] zero_tol;
    logic       tau_large;
    logic       input_short;
    logic [1:0] antenna_mode;
    logic       damping_on;
    logic       regulator_on;
    logic       rssi_step_high;
  } wkr_ana_t;

  // Whole state of the control block
  typedef struct packed {
    wkr_power_t                          power;
    wkr_chsel_t                          chsel;
    wkr_test_t                           test;
    wkr_mcfg_t                           mcfg;
    logic                                cs_s1;
    logic                                cs_s2;
    logic [2:0]                          det_s1;
    logic [2:0]                          det_s2;
    logic [2:0]                          dat_s1;
    logic [2:0]                          dat_s2;
    wkr_ch_state_t [2:0]                 ch_st;
    logic [2:0][`WKR_TMO_W-1:0]          tmo_cnt;
    logic [2:0]                          hit_pend;
    logic [2:0]                          wake_lat;
    logic                                por_wake;
    wkr_ana_t                            ana;
    logic                                wake_n;
    logic                                rssi_dout;
    logic                                rssi_oe_n;
    logic [2:0]                          ch_receive;
  } wkr_state_t;
endpackage

// file: tb/wkr_mcu_model.sv
// Controller-side model: turns bench write commands into the block's deframed write port.
// Assumes the bench raises cmd_go for one clk_sys cycle per register write.
`timescale 1ns/1ps

module wkr_mcu_model
  import wkr_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       cmd_go,
  input  wire logic [1:0] cmd_addr,
  input  wire logic [5:0] cmd_data,
  output logic            wr_stb,
  output logic [1:0]      wr_addr,
  output logic [5:0]      wr_data
);
  `include "wkr_defines.svh"

  // One registered write per command; address and data change only with the strobe
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_stb  <= 1'b0;
      wr_addr <= 2'h0;
      wr_data <= 6'h00;
    end
    else if (cmd_go)
    begin
      wr_stb  <= 1'b1;
      wr_addr <= cmd_addr;
      // Spare config bit always sent as zero, whatever the bench asks
      wr_data <= (cmd_addr == `WKR_ADDR_MCFG) ? (cmd_data & 6'h1f) : cmd_data;
    end
    else
    begin
      wr_stb <= 1'b0;
    end
  end
endmodule

// file: tb/wkr_ctrl_tb_top.sv
// Self-checking bench of the wake-up receiver control: register writes, power states, pin routing.
// Assumes the core package and wkr_defines.svh are compiled first; short receive timeout for run time.
`timescale 1ns/1ps

module wkr_ctrl_tb_top
  import wkr_pkg::*;
;
  `include "wkr_defines.svh"
  localparam int TMO = 20;

  logic       clk_sys = 1'b0;
  logic       nrst = 1'b0;
  logic       cmd_go = 1'b0;
  logic [1:0] cmd_addr = 2'h0;
  logic [5:0] cmd_data = 6'h00;
  logic       wr_stb;
  logic [1:0] wr_addr;
  logic [5:0] wr_data;
  logic       cs_pin = 1'b0;
  logic [2:0] sig_det = 3'h0;
  logic [2:0] rx_data = 3'h0;
  logic [2:0] matcher_hit = 3'h0;
  wkr_ana_t   ana_ctl;
  logic       wake_n;
  logic       rssi_dout;
  logic       rssi_oe_n;
  logic [2:0] ch_receive;
  int         bad_count = 0;
  int         samples_checked = 0;
  int         n;

  // 40 MHz system clock
  always #12.5 clk_sys = ~clk_sys;

  wkr_mcu_model i_mcu (.clk_sys(clk_sys), .nrst(nrst), .cmd_go(cmd_go), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data));

  wkr_ctrl #(.TIMEOUT_CYC(TMO)) i_dut (.clk_sys(clk_sys), .nrst(nrst), .wr_stb(wr_stb),
    .wr_addr(wr_addr), .wr_data(wr_data), .cs_pin(cs_pin), .sig_det(sig_det), .rx_data(rx_data),
    .matcher_hit(matcher_hit), .ana_ctl(ana_ctl), .wake_n(wake_n), .rssi_dout(rssi_dout),
    .rssi_oe_n(rssi_oe_n), .ch_receive(ch_receive));

  task automatic wrap_up();
    if (bad_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Settle point just after an edge, so registered outputs have landed
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk(input string name, input logic [2:0] exp, input logic [2:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Register write, then time for the output stage and the sync flops
  task automatic wr(input logic [1:0] a, input logic [5:0] d);
    @(posedge clk_sys);
    cmd_go   <= 1'b1;
    cmd_addr <= a;
    cmd_data <= d;
    @(posedge clk_sys);
    cmd_go <= 1'b0;
    tick(5);
  endtask

  // Bounded wait for a channel to reach receive
  task automatic wait_rx(input int ch);
    n = 0;
    while (ch_receive[ch] !== 1'b1 && n < 20)
    begin
      tick(1);
      n++;
    end
    chk("ch_receive", 3'h1, 3'(ch_receive[ch]));
    if (n >= 20)
      wrap_up();
  endtask

  task automatic hit(input int ch);
    @(posedge clk_sys);
    matcher_hit <= 3'(1 << ch);
    @(posedge clk_sys);
    matcher_hit <= 3'h0;
    tick(4);
  endtask

  // Clear and re-arm the wake pin, as the controller must after any wake
  task automatic release_wake();
    wr(`WKR_ADDR_CHSEL, 6'h20);
    chk("wake_n_release", 3'h1, 3'(wake_n));
    wr(`WKR_ADDR_CHSEL, 6'h00);
  endtask

  initial
  begin
    tick(4);
    nrst <= 1'b1;
    tick(4);
    // Power-on values seen through the front-end controls
    chk("tau_por", 3'h1, 3'(ana_ctl.tau_large));
    chk("tol_por", 3'h1, 3'(ana_ctl.zero_tol));
    chk("rep_por", 3'h0, 3'(ana_ctl.repeat_double));
    chk("clk_por", 3'h0, ana_ctl.matcher_clk_en);
    chk("wake_por", 3'h0, 3'(wake_n));
    chk("oe_por", 3'h1, 3'(rssi_oe_n));
    // Tolerance codes {hi,lo}: 00:3, 01:2, 10:1, 11:0
    for (int i = 0; i < 4; i++)
    begin
      wr(`WKR_ADDR_MCFG, 6'(i << 2) | 6'h01);
      chk("zero_tol", 3'(3 - ((i & 1) ? 1 : 0) - ((i & 2) ? 2 : 0)), 3'(ana_ctl.zero_tol));
      chk("clk_off", 3'h0, ana_ctl.matcher_clk_en);
      chk("tau_small", 3'h0, 3'(ana_ctl.tau_large));
    end
    wr(`WKR_ADDR_MCFG, 6'h12);
    chk("tau_large", 3'h1, 3'(ana_ctl.tau_large));
    chk("rep_double", 3'h1, 3'(ana_ctl.repeat_double));
    // Sleep, and writes still taken while asleep
    wr(`WKR_ADDR_POWER, 6'h08);
    chk("amp_sleep", 3'h0, ana_ctl.amp_on);
    wr(`WKR_ADDR_MCFG, 6'h18);
    chk("wr_in_sleep", 3'h0, 3'(ana_ctl.repeat_double));
    wr(`WKR_ADDR_POWER, 6'h0f);
    chk("amp_stby", 3'h7, ana_ctl.amp_on);
    chk("mpwr_stby", 3'h0, ana_ctl.matcher_pwr);
    wr(`WKR_ADDR_POWER, 6'h3f);
    chk("in_short", 3'h1, 3'(ana_ctl.input_short));
    chk("ant_mode", 3'h3, 3'(ana_ctl.antenna_mode));
    wr(`WKR_ADDR_POWER, 6'h0f);
    chk("in_open", 3'h0, 3'(ana_ctl.input_short));
    wr(`WKR_ADDR_CHSEL, 6'h10);
    chk("damping", 3'h1, 3'(ana_ctl.damping_on));
    release_wake();
    chk("wake_armed", 3'h1, 3'(wake_n));
    // Channel one into receive and a single-pattern wake
    sig_det <= 3'h1;
    wait_rx(0);
    tick(1);
    chk("mpwr_rx", 3'h1, ana_ctl.matcher_pwr);
    chk("clk_rx", 3'h1, ana_ctl.matcher_clk_en);
    hit(0);
    chk("wake_or", 3'h0, 3'(wake_n));
    // Aux pin digital, single wake of channel one beside combined wake pin
    cs_pin <= 1'b1;
    wr(`WKR_ADDR_TEST, 6'h02);
    wr(`WKR_ADDR_CHSEL, 6'h08);
    chk("aux_oe", 3'h0, 3'(rssi_oe_n));
    chk("aux_ch1", 3'h0, 3'(rssi_dout));
    chk("wake_comb", 3'h0, 3'(wake_n));
    wr(`WKR_ADDR_CHSEL, 6'h09);
    chk("aux_ch2", 3'h1, 3'(rssi_dout));
    wr(`WKR_ADDR_CHSEL, 6'h0b);
    chk("aux_comb", 3'h0, 3'(rssi_dout));
    // Diagnostic single wake on the wake pin, channel two then one
    wr(`WKR_ADDR_TEST, 6'h03);
    wr(`WKR_ADDR_CHSEL, 6'h09);
    chk("diag_w2", 3'h1, 3'(wake_n));
    wr(`WKR_ADDR_CHSEL, 6'h08);
    chk("diag_w1", 3'h0, 3'(wake_n));
    // Direct data of channel one on the wake pin
    wr(`WKR_ADDR_TEST, 6'h01);
    rx_data <= 3'h1;
    tick(5);
    chk("diag_d1", 3'h1, 3'(wake_n));
    rx_data <= 3'h0;
    tick(5);
    chk("diag_d0", 3'h0, 3'(wake_n));
    cs_pin <= 1'b0;
    tick(5);
    chk("aux_hiz", 3'h1, 3'(rssi_oe_n));
    wr(`WKR_ADDR_TEST, 6'h00);
    // Receive timeout once the signal disappears
    sig_det <= 3'h0;
    n = 0;
    while (ch_receive[0] === 1'b1 && n < 200)
    begin
      tick(1);
      n++;
    end
    chk("rx_tmo", 3'h1, 3'(n >= TMO && n <= TMO + 8));
    if (n >= 200)
      wrap_up();
    // Double-pattern mode needs two hits on channel one; channel two receives too
    release_wake();
    wr(`WKR_ADDR_MCFG, 6'h1a);
    sig_det <= 3'h3;
    wait_rx(0);
    wait_rx(1);
    hit(0);
    chk("dbl_first", 3'h1, 3'(wake_n));
    hit(0);
    chk("dbl_second", 3'h0, 3'(wake_n));
    // Matcher clocks off while receiving: hits give no wake
    release_wake();
    wr(`WKR_ADDR_MCFG, 6'h19);
    chk("clk_gate", 3'h0, ana_ctl.matcher_clk_en);
    hit(0);
    chk("no_wake_off", 3'h1, 3'(wake_n));
    wrap_up();
  end
endmodule
